// [design/synth_core.sv]
// Purpose: Serial-programmed feedback divider, pin-selected reference divider, phase detector
// Assumes: All pins asynchronous to clk; pin rates well below half of clk
// Notes:   Tri-state outputs are value plus enable; the wire is resolved outside
//
// How it works
// - Crystal is divided by one of 16,512,1024,2048,3668,4096,6144,8192
// - Feedback ratio accepted from 5 to 16383 inclusive
// - Feedback counter counts RF input edges and divides by latched ratio
// - Shift register advances one bit per serial clock rising edge, taking data
// - Word is 14 bits MSB first; after 14 edges LSB sits in stage one
// - Enable high copies shift register into ratio latch; low holds it
// - Lock indicator low when out of lock, high when locked
// - Passive and active outputs are three-state; differential pair also provided
// - Reference output carries a buffered copy of the crystal signal
`timescale 1ns/100ps
module synth_core (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic crystal_in,
  input  wire logic rf_in,
  input  wire logic serial_clk,
  input  wire logic serial_data,
  input  wire logic serial_enable,
  input  wire logic ref_ratio_sel_bit0,
  input  wire logic ref_ratio_sel_bit1,
  input  wire logic ref_ratio_sel_bit2,
  output logic      crystal_drive,
  output logic      ref_out,
  output logic      passive_filter_pump_out,
  output logic      passive_filter_pump_oe,
  output logic      active_filter_pump_out,
  output logic      active_filter_pump_oe,
  output logic      diff_pump_v,
  output logic      diff_pump_r,
  output logic      lock_indicator
);
  // Two-stage synchronisers, one bit per pin
  localparam int NSYNC = 8;
  logic [NSYNC-1:0] pins;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  // Third stage is the delayed copy used only for edge detection
  logic [NSYNC-1:0] s3_q;
  assign pins = {ref_ratio_sel_bit2, ref_ratio_sel_bit1, ref_ratio_sel_bit0,
                 serial_enable, serial_data, serial_clk, rf_in, crystal_in};

  logic       xtal_s, rf_s, sck_s, sdat_s, sen_s;
  logic [2:0] sel_s;
  logic       xtal_p, rf_p, sck_p;
  assign xtal_s = s2_q[0];
  assign rf_s   = s2_q[1];
  assign sck_s  = s2_q[2];
  assign sdat_s = s2_q[3];
  assign sen_s  = s2_q[4];
  assign sel_s  = s2_q[7:5];
  assign xtal_p = s3_q[0];
  assign rf_p   = s3_q[1];
  assign sck_p  = s3_q[2];

  logic [13:0] shift_q, shift_d;
  logic [13:0] latch_q, latch_d;
  logic [13:0] ncnt_q, ncnt_d;
  logic [13:0] rcnt_q, rcnt_d;
  logic        up_q, up_d;
  logic        dn_q, dn_d;
  logic [3:0]  width_q, width_d;
  logic [2:0]  good_q, good_d;
  logic        lock_q, lock_d;
  logic        crystal_drive_q, crystal_drive_d;
  logic        refo_q, refo_d;
  logic        pp_q, pp_d, pp_oe_q, pp_oe_d;
  logic        pa_q, pa_d, pa_oe_q, pa_oe_d;
  logic        dv_q, dv_d, dr_q, dr_d;

  logic [13:0] n_eff, r_eff;
  logic        n_tick, r_tick;

  // Rising edge of a synchronised pin against its one-clock-late copy
  function automatic logic rise(input logic now_v, input logic prev_v);
    return now_v && !prev_v;
  endfunction

  always_comb begin
    shift_d = shift_q;
    latch_d = latch_q;
    ncnt_d  = ncnt_q;
    rcnt_d  = rcnt_q;
    up_d    = up_q;
    dn_d    = dn_q;
    width_d = width_q;
    good_d  = good_q;
    lock_d  = lock_q;
    n_tick  = 1'b0;
    r_tick  = 1'b0;

    // Serial load: data sampled at the rising edge of the serial clock
    if (rise(sck_s, sck_p)) begin
      shift_d = {shift_q[12:0], sdat_s};
    end
    if (sen_s) begin
      latch_d = shift_q;
    end

    // Ratios below the legal minimum run at the minimum
    n_eff = (latch_q < synth_core_pkg::N_MIN) ? synth_core_pkg::N_MIN : latch_q;
    r_eff = synth_core_pkg::ref_ratio(sel_s);

    if (rise(rf_s, rf_p)) begin
      if (ncnt_q >= n_eff - 14'h0001) begin
        ncnt_d = synth_core_pkg::CNT_RESET;
        n_tick = 1'b1;
      end else begin
        ncnt_d = ncnt_q + 14'h0001;
      end
    end
    if (rise(xtal_s, xtal_p)) begin
      if (rcnt_q >= r_eff - 14'h0001) begin
        rcnt_d = synth_core_pkg::CNT_RESET;
        r_tick = 1'b1;
      end else begin
        rcnt_d = rcnt_q + 14'h0001;
      end
    end

    // Phase/frequency detector: first edge sets its flag, second clears both
    if (r_tick && n_tick) begin
      up_d = 1'b0;
      dn_d = 1'b0;
    end else if (r_tick) begin
      up_d = !dn_q;
      dn_d = 1'b0;
    end else if (n_tick) begin
      dn_d = !up_q;
      up_d = 1'b0;
    end

    // Lock: several compares in a row with error no wider than the window
    if (up_q || dn_q) begin
      width_d = (width_q == 4'hF) ? width_q : width_q + 4'h1;
    end
    if ((up_q || dn_q) && !(up_d || dn_d) || (r_tick && n_tick)) begin
      width_d = 4'h0;
      if (width_q <= synth_core_pkg::LOCK_WIN) begin
        good_d = (good_q == synth_core_pkg::LOCK_COUNT) ? good_q : good_q + 3'h1;
      end else begin
        good_d = 3'h0;
      end
    end
    if ((up_q || dn_q) && width_q > synth_core_pkg::LOCK_WIN) begin
      good_d = 3'h0;
    end
    lock_d = (good_d == synth_core_pkg::LOCK_COUNT);

    crystal_drive_d  = !xtal_s;
    refo_d  = xtal_s;
    pp_d    = up_d;
    pp_oe_d = up_d ^ dn_d;
    pa_d    = dn_d;
    pa_oe_d = up_d ^ dn_d;
    dv_d    = dn_d;
    dr_d    = up_d;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      shift_q <= synth_core_pkg::SHIFT_RESET;
      latch_q <= synth_core_pkg::N_RESET;
      ncnt_q  <= synth_core_pkg::CNT_RESET;
      rcnt_q  <= synth_core_pkg::CNT_RESET;
      up_q    <= 1'b0;
      dn_q    <= 1'b0;
      width_q <= 4'h0;
      good_q  <= 3'h0;
      lock_q  <= 1'b0;
      crystal_drive_q  <= 1'b0;
      refo_q  <= 1'b0;
      pp_q    <= 1'b0;
      pp_oe_q <= 1'b0;
      pa_q    <= 1'b0;
      pa_oe_q <= 1'b0;
      dv_q    <= 1'b0;
      dr_q    <= 1'b0;
    end else begin
      s1_q    <= pins;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      shift_q <= shift_d;
      latch_q <= latch_d;
      ncnt_q  <= ncnt_d;
      rcnt_q  <= rcnt_d;
      up_q    <= up_d;
      dn_q    <= dn_d;
      width_q <= width_d;
      good_q  <= good_d;
      lock_q  <= lock_d;
      crystal_drive_q  <= crystal_drive_d;
      refo_q  <= refo_d;
      pp_q    <= pp_d;
      pp_oe_q <= pp_oe_d;
      pa_q    <= pa_d;
      pa_oe_q <= pa_oe_d;
      dv_q    <= dv_d;
      dr_q    <= dr_d;
    end
  end

  assign crystal_drive           = crystal_drive_q;
  assign ref_out                 = refo_q;
  assign passive_filter_pump_out = pp_q;
  assign passive_filter_pump_oe  = pp_oe_q;
  assign active_filter_pump_out  = pa_q;
  assign active_filter_pump_oe   = pa_oe_q;
  assign diff_pump_v             = dv_q;
  assign diff_pump_r             = dr_q;
  assign lock_indicator          = lock_q;
endmodule

// [design/synth_core_pkg.sv]
// Purpose: Shared constants for the synthesizer digital core
// Assumes: Single 100 MHz system clock samples every pin
// Notes:   Reference ratios indexed by the three select bits
package synth_core_pkg;
  localparam int          N_WIDTH       = 14;
  localparam int          R_WIDTH       = 14;
  localparam int          SEL_WIDTH     = 3;
  localparam logic [13:0] N_MIN         = 14'h0005;
  localparam logic [13:0] N_RESET       = 14'h0005;
  localparam logic [13:0] SHIFT_RESET   = 14'h0000;
  localparam logic [13:0] CNT_RESET     = 14'h0000;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          LOCK_WIN_NS   = 50;
  localparam int          LOCK_WIN_CYC  = (LOCK_WIN_NS / CLK_PERIOD_NS < 1) ? 1 :
                                          LOCK_WIN_NS / CLK_PERIOD_NS;
  localparam logic [3:0]  LOCK_WIN      = LOCK_WIN_CYC[3:0];
  localparam logic [2:0]  LOCK_COUNT    = 3'h4;

  function automatic logic [13:0] ref_ratio(input logic [2:0] sel);
    case (sel)
      3'h0:    ref_ratio = 14'h0010;
      3'h1:    ref_ratio = 14'h0200;
      3'h2:    ref_ratio = 14'h0400;
      3'h3:    ref_ratio = 14'h0800;
      3'h4:    ref_ratio = 14'h0E54;
      3'h5:    ref_ratio = 14'h1000;
      3'h6:    ref_ratio = 14'h1800;
      default: ref_ratio = 14'h2000;
    endcase
  endfunction
endpackage

// [test/serial_host.sv]
// Purpose: Host model loading the feedback ratio over the serial port
// Assumes: Bench clock paces it, every pin level held at least four cycles
// Notes:   Idle data line shows the inverse of the last bit
`timescale 1ns/100ps
module serial_host (
  input  wire logic clk,
  output logic      serial_clk,
  output logic      serial_data,
  output logic      serial_enable
);
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    serial_enable = 1'b0;
  end
  task automatic send(input logic [13:0] word, input bit load);
    for (int i = 13; i >= 0; i--) begin
      @(posedge clk);
      serial_clk <= 1'b0;
      serial_data <= word[i];
      repeat (4) @(posedge clk);
      serial_clk <= 1'b1;
      repeat (3) @(posedge clk);
    end
    @(posedge clk);
    serial_clk <= 1'b0;
    serial_data <= ~serial_data;
    repeat (4) @(posedge clk);
    serial_enable <= load;
    repeat (8) @(posedge clk);
    serial_enable <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
endmodule

// [test/synth_core_props.sv]
// Purpose: Port assertions for synth_core
// Assumes: Outputs registered behind two sync flops
// Notes:   Bound to every synth_core
`timescale 1ns/100ps
module synth_core_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic crystal_in,
  input wire logic crystal_drive,
  input wire logic ref_out,
  input wire logic passive_filter_pump_out,
  input wire logic passive_filter_pump_oe,
  input wire logic active_filter_pump_out,
  input wire logic active_filter_pump_oe,
  input wire logic diff_pump_v,
  input wire logic diff_pump_r,
  input wire logic lock_indicator
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire oe = passive_filter_pump_oe;
  wire po = passive_filter_pump_out;
  sequence wide_err;
    oe [*8] ##1 !oe;
  endsequence
  AST_REF_COPY: assert property ($stable(crystal_in) [*5] |-> ref_out == crystal_in)
    else $error("ref_out stale");
  AST_DRIVE_INV: assert property (!$past(rst) |-> crystal_drive != ref_out)
    else $error("drive not inverse");
  AST_OE_PAIR: assert property (oe == active_filter_pump_oe)
    else $error("enables differ");
  AST_ACT_POL: assert property (oe |-> active_filter_pump_out != po)
    else $error("active polarity");
  AST_DIFF_DIR: assert property (oe |-> diff_pump_r == po && diff_pump_v != po)
    else $error("diff direction");
  AST_DIFF_IDLE: assert property (!oe |-> !diff_pump_r && !diff_pump_v)
    else $error("diff not idle");
  AST_DIR_HOLD: assert property (oe && $past(oe) |-> $stable(po))
    else $error("direction flipped");
  AST_WIDE_UNLOCK: assert property (wide_err |-> ##[0:3] !lock_indicator)
    else $error("lock kept");
endmodule
bind synth_core synth_core_props u_props (
  .clk                    (clk),
  .rst                    (rst),
  .crystal_in             (crystal_in),
  .crystal_drive          (crystal_drive),
  .ref_out                (ref_out),
  .passive_filter_pump_out(passive_filter_pump_out),
  .passive_filter_pump_oe (passive_filter_pump_oe),
  .active_filter_pump_out (active_filter_pump_out),
  .active_filter_pump_oe  (active_filter_pump_oe),
  .diff_pump_v            (diff_pump_v),
  .diff_pump_r            (diff_pump_r),
  .lock_indicator         (lock_indicator)
);

// [test/tb_top.sv]
// Purpose: Self-checking bench for synth_core
// Assumes: Divider pin edges three clocks apart
// Notes:   Reset lines up both divider counts
`timescale 1ns/100ps
module tb_top;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       xin = 1'b0;
  logic       rf = 1'b0;
  logic [2:0] sel = 3'h0;
  logic       sck, sda, sen, p_out, p_oe, d_v, d_r, lock;
  logic       drv, refo, a_out, a_oe;
  int         err_total = 0;
  int         checks = 0;
  int         n;
  wire  [5:0] pump = {p_oe, p_out, d_r, d_v, a_oe, a_out};
  always #5 clk = ~clk;
  serial_host u_host (.clk(clk), .serial_clk(sck), .serial_data(sda), .serial_enable(sen));
  synth_core u_dut (.clk(clk), .rst(rst), .crystal_in(xin), .rf_in(rf), .serial_clk(sck),
    .serial_data(sda), .serial_enable(sen), .ref_ratio_sel_bit0(sel[0]),
    .ref_ratio_sel_bit1(sel[1]), .ref_ratio_sel_bit2(sel[2]), .crystal_drive(drv),
    .ref_out(refo), .passive_filter_pump_out(p_out), .passive_filter_pump_oe(p_oe),
    .active_filter_pump_out(a_out), .active_filter_pump_oe(a_oe), .diff_pump_v(d_v),
    .diff_pump_r(d_r), .lock_indicator(lock));
  function automatic int ratio_of(input logic [2:0] s);
    int tab[8] = '{16, 512, 1024, 2048, 3668, 4096, 6144, 8192};
    return tab[s];
  endfunction
  // Pattern {oe, out, up, down, active oe, active out} after one leading tick
  function automatic logic [5:0] pump_exp(input bit up);
    return up ? 6'h3A : 6'h27;
  endfunction
  task automatic chk(input logic [5:0] got, input logic [5:0] want);
    checks++;
    if (got !== want) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic chk_lvl(input logic [1:0] got, input logic [1:0] want);
    checks++;
    if (got !== want) begin
      err_total++;
      $display("wrong value at %0t: level got %b want %b", $time, got, want);
    end
  endtask
  task automatic pulse(input int cnt, input bit x, input bit r);
    repeat (cnt) begin
      @(posedge clk);
      xin <= x;
      rf <= r;
      @(posedge clk);
      xin <= 1'b0;
      rf <= 1'b0;
      @(posedge clk);
    end
    repeat (8) @(posedge clk);
    #1;
  endtask
  // Holds the crystal pin at one level and looks at the inverted drive and the buffered copy
  task automatic xin_level(input bit x);
    @(posedge clk);
    xin <= x;
    repeat (6) @(posedge clk);
    #1;
    chk_lvl({drv, refo}, {~x, x});
  endtask
  task automatic reset_dut();
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge clk);
    err_total++;
    results();
  end
  initial begin
    void'($urandom(34409));
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      sel <= s[2:0];
      reset_dut();
      pulse(ratio_of(s[2:0]) - 1, 1'b1, 1'b0);
      chk(pump, 6'h00);
      pulse(1, 1'b1, 1'b0);
      chk(pump, pump_exp(1'b1));
    end
    @(posedge clk);
    sel <= 3'h0;
    for (int k = 0; k < 4; k++) begin
      n = (k == 0) ? 5 : 5 + $urandom % 296;
      reset_dut();
      u_host.send(n[13:0], 1'b1);
      pulse(n - 1, 1'b0, 1'b1);
      chk(pump, 6'h00);
      pulse(1, 1'b0, 1'b1);
      chk(pump, pump_exp(1'b0));
      pulse(16, 1'b1, 1'b0);
      chk(pump, 6'h00);
      u_host.send(14'(n + 1 + $urandom % 50), 1'b0);
      pulse(n, 1'b0, 1'b1);
      chk(pump, pump_exp(1'b0));
    end
    reset_dut();
    u_host.send(14'h0003, 1'b1);
    pulse(4, 1'b0, 1'b1);
    chk(pump, 6'h00);
    pulse(1, 1'b0, 1'b1);
    chk(pump, pump_exp(1'b0));
    reset_dut();
    u_host.send(14'h0010, 1'b1);
    pulse(96, 1'b1, 1'b1);
    chk_lvl({1'b0, lock}, 2'h1);
    pulse(3, 1'b1, 1'b0);
    pulse(32, 1'b1, 1'b1);
    chk_lvl({1'b0, lock}, 2'h0);
    xin_level(1'b1);
    xin_level(1'b0);
    results();
  end
endmodule
